/* hw/sar_pkg.sv */
package sar_pkg;

	// ---------------------------------------------------------------
	// register map: printed offsets are indices, byte address = 4*index
	// ---------------------------------------------------------------
	localparam logic [11:0] IDX_RESULT_LOW  = 12'h06F;
	localparam logic [11:0] IDX_RESULT_HIGH = 12'h070;
	localparam logic [11:0] IDX_CTRL_STATUS = 12'h071;
	localparam logic [11:0] ADDR_RESULT_LOW  = 12'(IDX_RESULT_LOW  * 4);
	localparam logic [11:0] ADDR_RESULT_HIGH = 12'(IDX_RESULT_HIGH * 4);
	localparam logic [11:0] ADDR_CTRL_STATUS = 12'(IDX_CTRL_STATUS * 4);

	// ---------------------------------------------------------------
	// control/status field positions and reset value
	// ---------------------------------------------------------------
	localparam int          POS_DONE  = 7;
	localparam int          POS_FAST  = 6;
	localparam int          POS_ON    = 5;
	localparam int          POS_HALVE = 4;
	localparam int          POS_SEL   = 0;
	localparam logic [7:0]  CSR_RESET = 8'h00;
	localparam logic [9:0]  RESULT_RESET = 10'h000;

	// ---------------------------------------------------------------
	// conversion timing, in conversion clock periods
	// ---------------------------------------------------------------
	localparam int          RESULT_BITS   = 10;
	localparam logic [3:0]  SAMPLE_TICKS  = 4'h4;
	localparam logic [3:0]  TRIAL_TICKS   = 4'h4;
	localparam logic [1:0]  DIV_ONE       = 2'h0;
	localparam logic [1:0]  DIV_TWO       = 2'h1;
	localparam logic [1:0]  DIV_FOUR      = 2'h3;

	typedef enum logic [1:0] {PH_IDLE, PH_SAMPLE, PH_TRIAL} phase_t;

	typedef struct packed {
		logic       done;
		logic       fast;
		logic       on;
		logic       halve;
		logic [2:0] sel;
	} csr_t;

	typedef struct packed {
		logic       enable;
		logic       sample;
		logic [2:0] sel;
		logic [9:0] code;
	} analog_ctl_t;

endpackage

/* hw/sar_converter_control.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: ten-bit successive approximation with sample phase
// R2: three-bit select picks inputs zero to five
// R3: converter_on set starts continuous conversions
// R4: clearing converter_on stops conversion at once
// R5: completion stores result, sets done flag
// R6: high read or status write clears flag
// R7: low read locks high byte until read
// R8: fast/halve bits pick divide by 1,2,4
// R9: undivided clock only when CPU at most 4MHz
// R10: software sets clock bits before converter_on
// R11: high gives bits 9:2, low gives 1:0
// R12: out of range saturates, no overflow flag
// R13: done flag read-only, status resets to zero
// R14: runs in wait, stopped in halt
// R15: locked result registers keep their contents
// R16: no interrupt, software polls done flag
module sar_converter_control
	import sar_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic [31:0] hrdata,
	output var  logic        hreadyout,
	output var  logic        hresp,
	input  wire logic        halt_mode,
	input  wire logic        cmp_above,
	output var  analog_ctl_t analog_ctl
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		csr_t        csr;
		logic [9:0]  result;
		logic        lock;
		phase_t      phase;
		logic [1:0]  div_cnt;
		logic [3:0]  tick_cnt;
		logic [3:0]  bit_idx;
		logic [9:0]  sar;
		logic        cmp_meta;
		logic        cmp_sync;
		logic        wr_pend;
		logic [11:0] wr_addr;
		logic [31:0] rdata;
		logic        ready;
		analog_ctl_t ana;
	} state_t;

	state_t st_r;
	state_t st_nxt;
	logic   tick;
	logic   conv_done;
	logic   take;
	logic   rd_low;
	logic   rd_high;
	logic   wr_csr;
	logic   run;
	logic [1:0] div_max;
	logic [11:0] a_low;

	assign a_low = haddr[11:0];

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		// comparator is asynchronous to hclk; only the second stage is used
		st_nxt.cmp_meta = cmp_above;
		st_nxt.cmp_sync = st_r.cmp_meta;

		take    = hsel && hready && htrans[1];
		rd_low  = take && !hwrite && (a_low == ADDR_RESULT_LOW);
		rd_high = take && !hwrite && (a_low == ADDR_RESULT_HIGH);
		wr_csr  = st_r.wr_pend && (st_r.wr_addr == ADDR_CTRL_STATUS);

		// conversion clock divider [R8]
		if (st_r.csr.fast && !st_r.csr.halve) begin
			div_max = DIV_ONE;
		end else if (st_r.csr.fast == st_r.csr.halve) begin
			div_max = DIV_TWO;
		end else begin
			div_max = DIV_FOUR;
		end
		// at or past the limit, so a count left from a wider divide cannot skip a tick
		tick = (st_r.div_cnt >= div_max);
		st_nxt.div_cnt = tick ? 2'h0 : st_r.div_cnt + 2'h1;

		// halt stops the converter; wait mode has no input here at all [R14]
		run = st_r.csr.on && !halt_mode; // [R3] [R4]
		conv_done = 1'b0;

		// successive approximation sequence [R1]
		unique case (st_r.phase)
			PH_IDLE: begin
				if (run) begin
					st_nxt.phase    = PH_SAMPLE;
					st_nxt.tick_cnt = 4'h0;
					st_nxt.div_cnt  = 2'h0;
				end
			end
			PH_SAMPLE: begin
				if (tick) begin
					st_nxt.tick_cnt = st_r.tick_cnt + 4'h1;
					if (st_r.tick_cnt == SAMPLE_TICKS - 4'h1) begin
						st_nxt.phase    = PH_TRIAL;
						st_nxt.tick_cnt = 4'h0;
						st_nxt.bit_idx  = 4'(RESULT_BITS - 1);
						st_nxt.sar      = 10'h200;
					end
				end
			end
			PH_TRIAL: begin
				if (tick) begin
					st_nxt.tick_cnt = st_r.tick_cnt + 4'h1;
					if (st_r.tick_cnt == TRIAL_TICKS - 4'h1) begin
						st_nxt.tick_cnt = 4'h0;
						// comparator low drops the trial bit; saturates at the rails [R12]
						if (!st_r.cmp_sync) begin
							st_nxt.sar[st_r.bit_idx] = 1'b0;
						end
						if (st_r.bit_idx == 4'h0) begin
							conv_done    = 1'b1;
							st_nxt.phase = PH_SAMPLE; // continuous [R3]
						end else begin
							st_nxt.bit_idx = st_r.bit_idx - 4'h1;
							st_nxt.sar[st_r.bit_idx - 4'h1] = 1'b1;
						end
					end
				end
			end
		endcase
		if (!run) begin
			st_nxt.phase = PH_IDLE; // [R4] [R14]
			st_nxt.sar   = 10'h000;
		end

		// result store; a pending lock keeps the old pair intact [R5] [R15]
		// a low read in the same cycle counts as locked, so the pair stays one sample [R7]
		if (conv_done && !st_r.lock && !rd_low) begin
			st_nxt.result = st_nxt.sar;
			if (!st_r.cmp_sync) begin
				st_nxt.result[0] = 1'b0;
			end
		end

		// ---------------------------------------------------------------
		// bus: address phase
		// ---------------------------------------------------------------
		st_nxt.wr_pend = take && hwrite;
		st_nxt.wr_addr = a_low;
		st_nxt.ready   = 1'b1;
		st_nxt.rdata   = 32'h0000_0000;
		if (take && !hwrite) begin
			unique case (a_low)
				ADDR_RESULT_LOW:  st_nxt.rdata = {30'h0, st_r.result[1:0]};  // [R11]
				ADDR_RESULT_HIGH: st_nxt.rdata = {24'h0, st_r.result[9:2]};  // [R11]
				ADDR_CTRL_STATUS: st_nxt.rdata = {24'h0, st_r.csr.done, st_r.csr.fast,
					st_r.csr.on, st_r.csr.halve, 1'b0, st_r.csr.sel};
				default:          st_nxt.rdata = 32'h0000_0000;
			endcase
		end
		if (rd_low) begin
			st_nxt.lock = 1'b1; // [R7]
		end
		if (rd_high) begin
			st_nxt.lock = 1'b0; // [R7]
		end

		// ---------------------------------------------------------------
		// bus: data phase write; done stays read-only [R13]
		// ---------------------------------------------------------------
		if (wr_csr) begin
			st_nxt.csr.fast  = hwdata[POS_FAST];
			st_nxt.csr.on    = hwdata[POS_ON];
			st_nxt.csr.halve = hwdata[POS_HALVE];
			st_nxt.csr.sel   = hwdata[POS_SEL +: 3]; // [R2]
		end
		// set wins over a clear in the same cycle [R5] [R6]
		st_nxt.csr.done = conv_done || (st_r.csr.done && !rd_high && !wr_csr);

		// analog side; codes 6 and 7 pass through and pick no input on the mux [R2]
		st_nxt.ana.enable = run;
		st_nxt.ana.sample = (st_nxt.phase == PH_SAMPLE);
		st_nxt.ana.sel    = st_nxt.csr.sel;
		st_nxt.ana.code   = st_nxt.sar;
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r          <= '0;
			st_r.csr      <= csr_t'(CSR_RESET[6:0]); // [R13]
			st_r.result   <= RESULT_RESET;
			st_r.phase    <= PH_IDLE;
			st_r.ready    <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// no interrupt output exists; completion is seen only by polling [R16]
	assign hrdata     = st_r.rdata;
	assign hreadyout  = st_r.ready;
	assign hresp      = 1'b0;
	assign analog_ctl = st_r.ana;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_high_rd_clears: assert property (@(posedge hclk) disable iff (!hresetn) // [R6]
		rd_high && !conv_done |=> !st_r.csr.done)
		else $error("done flag survived a high result read");

	a_csr_wr_clears: assert property (@(posedge hclk) disable iff (!hresetn) // [R6]
		wr_csr && !conv_done |=> !st_r.csr.done)
		else $error("done flag survived a status write");

	a_done_sets: assert property (@(posedge hclk) disable iff (!hresetn) // [R5]
		conv_done |=> st_r.csr.done)
		else $error("done flag not set after conversion");

	a_lock_freezes: assert property (@(posedge hclk) disable iff (!hresetn) // [R15]
		st_r.lock && !rd_high |=> $stable(st_r.result))
		else $error("locked result changed");

	a_low_rd_locks: assert property (@(posedge hclk) disable iff (!hresetn) // [R7]
		rd_low |=> st_r.lock && st_r.rdata[31:2] == 30'h0)
		else $error("low read did not lock or returned upper bits");

	a_off_stops: assert property (@(posedge hclk) disable iff (!hresetn) // [R4]
		!st_r.csr.on |=> st_r.phase == PH_IDLE && !st_r.ana.enable)
		else $error("converter active while switched off");

	a_halt_stops: assert property (@(posedge hclk) disable iff (!hresetn) // [R14]
		halt_mode |=> st_r.phase == PH_IDLE)
		else $error("converter active in halt");

	a_start_conv: assert property (@(posedge hclk) disable iff (!hresetn) // [R3]
		st_r.phase == PH_IDLE && st_r.csr.on && !halt_mode
			|=> st_r.phase == PH_SAMPLE && st_r.ana.sample)
		else $error("conversion did not start");

	a_fast_clock: assert property (@(posedge hclk) disable iff (!hresetn) // [R8]
		st_r.csr.fast && !st_r.csr.halve |-> tick)
		else $error("undivided conversion clock missed a tick");

	a_quarter_clock: assert property (@(posedge hclk) disable iff (!hresetn) // [R8]
		st_r.csr.halve && !st_r.csr.fast && tick
			##1 (st_r.csr.halve && !st_r.csr.fast) |-> !tick [*3])
		else $error("quarter conversion clock ticked early");

	a_sel_follows: assert property (@(posedge hclk) disable iff (!hresetn) // [R2]
		##1 st_r.ana.sel == st_r.csr.sel)
		else $error("analog select differs from input_select");

	a_saturate: assert property (@(posedge hclk) disable iff (!hresetn) // [R12]
		conv_done && !st_r.lock && !rd_low && st_r.sar == 10'h3FF && st_r.cmp_sync
			|=> st_r.result == 10'h3FF)
		else $error("full scale result not stored");

	// the pair changes only at a completion, and a locked pair not even then
	a_result_hold: assert property (@(posedge hclk) disable iff (!hresetn) // [R5]
		!conv_done |=> $stable(st_r.result))
		else $error("result changed without a completion");

	a_high_rd_unlocks: assert property (@(posedge hclk) disable iff (!hresetn) // [R7]
		rd_high |=> !st_r.lock)
		else $error("high result read left the pair locked");

	a_high_bits: assert property (@(posedge hclk) disable iff (!hresetn) // [R11]
		rd_high |=> st_r.rdata == {24'h0, $past(st_r.result[9:2])})
		else $error("high result read returned wrong bits");

	a_low_bits: assert property (@(posedge hclk) disable iff (!hresetn) // [R11]
		rd_low |=> st_r.rdata[1:0] == $past(st_r.result[1:0]))
		else $error("low result read returned wrong bits");

	a_status_fields: assert property (@(posedge hclk) disable iff (!hresetn) // [R13]
		take && !hwrite && a_low == ADDR_CTRL_STATUS
			|=> st_r.rdata[31:8] == 24'h0 && !st_r.rdata[3])
		else $error("status read returned bits outside its fields");

	a_half_clock: assert property (@(posedge hclk) disable iff (!hresetn) // [R8]
		st_r.csr.fast == st_r.csr.halve && tick
			##1 (st_r.csr.fast == st_r.csr.halve) |-> !tick)
		else $error("half conversion clock ticked early");

	a_on_enables: assert property (@(posedge hclk) disable iff (!hresetn) // [R3]
		st_r.csr.on && !halt_mode |=> st_r.ana.enable)
		else $error("converter not powered while switched on");

endmodule // sar_converter_control
`default_nettype wire

/* verification/sar_converter_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sar_converter_control_tb_top;
	import sar_pkg::*;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        halt_mode = 1'b0;
	logic        cmp_above = 1'b0;
	analog_ctl_t analog_ctl;
	logic [10:0] vin2 = 11'h001;
	logic [31:0] rd;
	logic [7:0]  csr;
	logic [9:0]  v;
	int          div;
	int          per;
	int          n_fail = 0;
	int          checks_done = 0;

	always #50 hclk = ~hclk;
	// vin2 is twice the input plus a half step, so it never ties with a trial code
	always @(posedge hclk) cmp_above <= (vin2 > {analog_ctl.code, 1'b0});

	sar_converter_control dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .halt_mode(halt_mode), .cmp_above(cmp_above),
		.analog_ctl(analog_ctl)
	);

	// ----------------------------------------
	// bus and compare tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out;
		if (n_fail == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// entered just after a rising edge; leaves just after the data phase edge
	task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		check(rd, {24'h0, e});
	endtask

	task automatic wait_done;
		int k;
		k = 0;
		rd = 32'h0;
		while (rd[7] !== 1'b1 && k < 400) begin
			bus(1'b0, ADDR_CTRL_STATUS, 8'h00);
			k++;
		end
		check(32'(rd[7]), 32'h0000_0001);
	endtask

	// first pass locks onto a sampling start, second counts one whole period
	task automatic sample_period(output int n);
		repeat (2) begin
			n = 0;
			while (analog_ctl.sample !== 1'b0 && n < 999) begin
				@(posedge hclk);
				n++;
			end
			while (analog_ctl.sample !== 1'b1 && n < 999) begin
				@(posedge hclk);
				n++;
			end
		end
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_chk(ADDR_CTRL_STATUS, CSR_RESET);
		rd_chk(ADDR_RESULT_HIGH, 8'h00);
		rd_chk(ADDR_RESULT_LOW, 8'h00);
		bus(1'b1, ADDR_CTRL_STATUS, 8'hDF);
		rd_chk(ADDR_CTRL_STATUS, 8'h57);
		bus(1'b1, ADDR_RESULT_HIGH, 8'hFF);
		rd_chk(ADDR_RESULT_HIGH, 8'h00);
		rd_chk(12'h200, 8'h00);
		check(32'(analog_ctl.enable), 32'h0000_0000);
		check(32'(analog_ctl.sel), 32'h0000_0007);
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 10'h3FF : 10'((i - 1) * 10'h0B3);
			vin2 = {v, 1'b1};
			div = (i % 3 == 2) ? 4 : 2;
			// the undivided setting stays out of conversions at this clock rate
			csr = {1'b0, (i % 3 == 0), 1'b0, (i % 3 != 1), 1'b0, 3'(i)};
			bus(1'b1, ADDR_CTRL_STATUS, csr);
			bus(1'b1, ADDR_CTRL_STATUS, csr | 8'h20);
			sample_period(per);
			check(32'(per), 32'(44 * div));
			check(32'(analog_ctl.sel), 32'(i));
			check(32'(analog_ctl.enable), 32'h0000_0001);
			wait_done;
			rd_chk(ADDR_RESULT_LOW, {6'h0, v[1:0]});
			rd_chk(ADDR_RESULT_HIGH, v[9:2]);
			rd_chk(ADDR_CTRL_STATUS, csr | 8'h20);
			bus(1'b1, ADDR_CTRL_STATUS, csr);
		end
		vin2 = {10'h155, 1'b1};
		bus(1'b1, ADDR_CTRL_STATUS, 8'h50);
		bus(1'b1, ADDR_CTRL_STATUS, 8'h70);
		wait_done;
		rd_chk(ADDR_RESULT_LOW, 8'h01);
		vin2 = {10'h2AA, 1'b1};
		sample_period(per);
		rd_chk(ADDR_RESULT_LOW, 8'h01);
		rd_chk(ADDR_RESULT_HIGH, 8'h55);
		wait_done;
		rd_chk(ADDR_RESULT_HIGH, 8'hAA);
		wait_done;
		bus(1'b1, ADDR_CTRL_STATUS, 8'h70);
		rd_chk(ADDR_CTRL_STATUS, 8'h70);
		halt_mode <= 1'b1;
		repeat (3) @(posedge hclk);
		check(32'(analog_ctl.enable), 32'h0000_0000);
		halt_mode <= 1'b0;
		sample_period(per);
		check(32'(per), 32'(44 * 2));
		bus(1'b1, ADDR_CTRL_STATUS, 8'h40);
		repeat (3) @(posedge hclk);
		check(32'(analog_ctl.enable), 32'h0000_0000);
		check(32'(analog_ctl.sample), 32'h0000_0000);
		// undivided setting written only with the converter off
		rd_chk(ADDR_CTRL_STATUS, 8'h40);
		close_out;
	end

	// the whole sequence needs well under 10000 cycles
	initial begin
		repeat (20000) @(posedge hclk);
		n_fail++;
		close_out;
	end
endmodule // sar_converter_control_tb_top
`default_nettype wire
